// *** src/mfio_register_bank.sv ***
// host-facing register bank of a multifunction acquisition board
// assumes host strobes and address come from pins (synchronised here) and
// converter status and digital inputs are external pins as well
//
// Function
// - decode exactly sixteen ports from base; offset F reserved both ways
// - offsets 0..2 pass to timer counters; 3 writes control word only
// - read offset 4 returns result bits 7..0
// - read offset 5 gives result 11..8, busy on bit 4, zeros above
// - busy reads one during conversion, zero once result ready
// - writes at 4 and 5 load first dac low byte then nibble
// - writes at 6 and 7 load second dac the same way
// - dacs double buffered; nibble write moves staged byte into output
// - reads at 6 and 7 return sixteen digital input levels
// - interrupt mode sets status bit on each conversion end, requests irq
// - any write at 8 clears status unless a completion sets it that same cycle; next completion sets it again
// - write at 9 stores four-bit gain code from bits 3..0
// - low-gain variant maps codes to bipolar or unipolar gains 1..8, 0.5
// - high-gain variant maps codes to gains 1..1000 and 0.5..500
// - writes A..E go to mux, mode, trigger, output low, output high
// - any write at C pulses the converter trigger and sets busy
`timescale 1ns/10ps

module mfio_register_bank
    import mfio_pkg::*;
#(
    parameter variant_e VARIANT = LOW_GAIN_VARIANT
) (
    input  wire logic              clk,
    input  wire logic              reset_n,
    input  wire logic              clk_en,
    input  wire logic              port_select_n,
    input  wire logic [ADDR_W-1:0] port_offset,
    input  wire logic              io_read_n,
    input  wire logic              io_write_n,
    input  wire logic [DATA_W-1:0] host_data_in,
    output logic      [DATA_W-1:0] host_data_out,
    output logic                   host_data_oe,
    input  wire logic [DATA_W-1:0] timer_data_in,
    output logic      [DATA_W-1:0] timer_data_out,
    output logic                   timer_data_oe,
    output logic      [1:0]        timer_addr,
    output logic                   timer_rd_n,
    output logic                   timer_wr_n,
    input  wire logic [RES_W-1:0]  conv_result,
    input  wire logic              conv_done,
    input  wire logic              pacer_trigger,
    output logic                   conv_trigger,
    output logic                   conv_busy,
    output logic                   irq_request,
    input  wire logic [DIN_W-1:0]  digital_input_word,
    output logic      [DIN_W-1:0]  digital_output_word,
    output logic      [RES_W-1:0]  dac_first_out,
    output logic      [RES_W-1:0]  dac_second_out,
    output logic      [GAIN_W-1:0] gain_code_bits,
    output gain_sel_s              gain_select,
    output logic      [CHAN_W-1:0] channel_select,
    output logic      [MODE_W-1:0] conversion_mode
);

    // pin synchronisers; first stage feeds only the second
    host_cycle_s       host_s1_reg;
    host_cycle_s       host_s2_reg;
    logic              sel_s1_reg;
    logic              sel_s2_reg;
    logic [RES_W-1:0]  res_s1_reg;
    logic [RES_W-1:0]  res_s2_reg;
    logic [2:0]        done_s_reg;
    logic [2:0]        pacer_s_reg;
    logic [DIN_W-1:0]  din_s1_reg;
    logic [DIN_W-1:0]  din_s2_reg;
    logic [DATA_W-1:0] tdat_s1_reg;
    logic [DATA_W-1:0] tdat_s2_reg;
    logic              rd_prev_reg;
    logic              wr_prev_reg;

    logic              rd_start;
    logic              wr_start;
    logic              rd_active;
    logic              wr_done;
    logic              done_rise;
    logic              pacer_rise;
    logic              sw_trigger;

    logic [7:0]        dac_first_stage_reg;
    logic [7:0]        dac_second_stage_reg;
    logic              int_status_reg;
    logic [7:0]        rd_mux;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            host_s1_reg <= '0;
            host_s2_reg <= '0;
            sel_s1_reg  <= 1'b0;
            sel_s2_reg  <= 1'b0;
            res_s1_reg  <= RST_DAC;
            res_s2_reg  <= RST_DAC;
            done_s_reg  <= RST_MODE;
            pacer_s_reg <= RST_MODE;
            din_s1_reg  <= '0;
            din_s2_reg  <= '0;
            tdat_s1_reg <= RST_BYTE;
            tdat_s2_reg <= RST_BYTE;
            rd_prev_reg <= 1'b0;
            wr_prev_reg <= 1'b0;
        end else if (clk_en) begin
            host_s1_reg <= '{rd: ~io_read_n, wr: ~io_write_n,
                             ofs: port_offset, data: host_data_in};
            host_s2_reg <= host_s1_reg;
            sel_s1_reg  <= ~port_select_n;
            sel_s2_reg  <= sel_s1_reg;
            res_s1_reg  <= conv_result;
            res_s2_reg  <= res_s1_reg;
            done_s_reg  <= {done_s_reg[1:0], conv_done};
            pacer_s_reg <= {pacer_s_reg[1:0], pacer_trigger};
            din_s1_reg  <= digital_input_word;
            din_s2_reg  <= din_s1_reg;
            tdat_s1_reg <= timer_data_in;
            tdat_s2_reg <= tdat_s1_reg;
            rd_prev_reg <= host_s2_reg.rd & sel_s2_reg;
            wr_prev_reg <= host_s2_reg.wr & sel_s2_reg;
        end
    end

    assign rd_active  = host_s2_reg.rd & sel_s2_reg;
    assign rd_start   = rd_active & ~rd_prev_reg;
    assign wr_start   = host_s2_reg.wr & sel_s2_reg & ~wr_prev_reg;
    // writes act on the trailing edge so data has settled on the bus
    assign wr_done    = wr_prev_reg & ~(host_s2_reg.wr & sel_s2_reg);
    assign done_rise  = done_s_reg[1] & ~done_s_reg[2];
    assign pacer_rise = pacer_s_reg[1] & ~pacer_s_reg[2];

    // write data and offset resampled every strobe cycle; last sample is used at strobe end
    host_cycle_s wr_hold_reg;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_hold_reg <= '0;
        end else if (clk_en && (wr_start || wr_prev_reg)) begin
            wr_hold_reg <= host_s2_reg;
        end
    end

    // software trigger on write at offset C
    assign sw_trigger = wr_done && wr_hold_reg.ofs == OFS_TRIGGER;

    always_comb begin
        unique case (host_s2_reg.ofs)
            OFS_TIMER_ZERO, OFS_TIMER_ONE, OFS_TIMER_TWO:
                rd_mux = tdat_s2_reg;
            OFS_RES_LOW:
                rd_mux = res_s2_reg[7:0];
            OFS_RES_HIGH:
                rd_mux = {3'h0, conv_busy, res_s2_reg[11:8]};
            OFS_DAC1_LOW:
                rd_mux = din_s2_reg[7:0];
            OFS_DAC1_HIGH:
                rd_mux = din_s2_reg[15:8];
            default:
                rd_mux = RD_RESERVED;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            host_data_out <= RST_BYTE;
            host_data_oe  <= 1'b0;
        end else if (clk_en) begin
            host_data_oe <= rd_active;
            if (rd_active) begin
                host_data_out <= rd_mux;
            end
        end
    end

    // timer strobes for offsets 0..3, read at 3 not passed
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            timer_addr     <= 2'h0;
            timer_rd_n     <= 1'b1;
            timer_wr_n     <= 1'b1;
            timer_data_out <= RST_BYTE;
            timer_data_oe  <= 1'b0;
        end else if (clk_en) begin
            timer_addr     <= host_s2_reg.ofs[1:0];
            timer_rd_n     <= ~(rd_active && host_s2_reg.ofs < OFS_TIMER_CTRL);
            timer_wr_n     <= ~(host_s2_reg.wr && sel_s2_reg &&
                                host_s2_reg.ofs <= OFS_TIMER_CTRL);
            timer_data_out <= host_s2_reg.data;
            timer_data_oe  <= host_s2_reg.wr && sel_s2_reg &&
                              host_s2_reg.ofs <= OFS_TIMER_CTRL;
        end
    end

    // first dac, second dac, double buffering, reset zero
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dac_first_stage_reg  <= RST_BYTE;
            dac_second_stage_reg <= RST_BYTE;
            dac_first_out        <= RST_DAC;
            dac_second_out       <= RST_DAC;
        end else if (clk_en && wr_done) begin
            unique case (wr_hold_reg.ofs)
                OFS_RES_LOW:   dac_first_stage_reg <= wr_hold_reg.data;
                OFS_RES_HIGH:  dac_first_out <=
                    {wr_hold_reg.data[3:0], dac_first_stage_reg};
                OFS_DAC1_LOW:  dac_second_stage_reg <= wr_hold_reg.data;
                OFS_DAC1_HIGH: dac_second_out <=
                    {wr_hold_reg.data[3:0], dac_second_stage_reg};
                default: ;
            endcase
        end
    end

    // gain code, mux, mode and digital outputs
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            gain_code_bits      <= RST_GAIN;
            channel_select      <= RST_GAIN;
            conversion_mode     <= RST_MODE;
            digital_output_word <= '0;
        end else if (clk_en && wr_done) begin
            unique case (wr_hold_reg.ofs)
                OFS_GAIN:      gain_code_bits <= wr_hold_reg.data[3:0];
                OFS_CHANNEL:   channel_select <= wr_hold_reg.data[3:0];
                OFS_MODE:      conversion_mode <= wr_hold_reg.data[2:0];
                OFS_DOUT_LOW:  digital_output_word[7:0] <= wr_hold_reg.data;
                OFS_DOUT_HIGH: digital_output_word[15:8] <= wr_hold_reg.data;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            gain_select <= '0;
        end else if (clk_en) begin
            gain_select.unipolar_range <= gain_code_bits[GAIN_UNI_BIT] &
                                          ~gain_code_bits[GAIN_HALF_BIT];
            gain_select.bipolar_range  <= ~gain_code_bits[GAIN_UNI_BIT] |
                                          gain_code_bits[GAIN_HALF_BIT];
            gain_select.gain_step      <= gain_code_bits[1:0];
            gain_select.half_family    <= gain_code_bits[GAIN_HALF_BIT];
            if (VARIANT == LOW_GAIN_VARIANT) begin
                gain_select.code_valid <= ~gain_code_bits[GAIN_HALF_BIT] ||
                                          gain_code_bits == 4'h8;
            end else begin
                gain_select.code_valid <= ~(gain_code_bits[GAIN_HALF_BIT] &
                                            gain_code_bits[GAIN_UNI_BIT]);
            end
        end
    end

    // trigger pulse and busy until completion
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            conv_trigger <= 1'b0;
            conv_busy    <= 1'b0;
        end else if (clk_en) begin
            conv_trigger <= sw_trigger | pacer_rise;
            if (sw_trigger || pacer_rise) begin
                conv_busy <= 1'b1;
            end else if (done_rise) begin
                conv_busy <= 1'b0;
            end
        end
    end

    // status set in interrupt mode, write at 8 clears, set wins
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            int_status_reg <= 1'b0;
            irq_request    <= 1'b0;
        end else if (clk_en) begin
            if (done_rise && conversion_mode == MODE_INTERRUPT) begin
                int_status_reg <= 1'b1;
            end else if (wr_done && wr_hold_reg.ofs == OFS_INT_CLEAR) begin
                int_status_reg <= 1'b0;
            end
            irq_request <= int_status_reg;
        end
    end

endmodule

// *** common/mfio_pkg.sv ***
// constants, field layouts and carriers for the multifunction io register bank
// assumes an 8-bit host port bus with a four-bit offset inside the window
package mfio_pkg;

    localparam int          ADDR_W        = 4;
    localparam int          DATA_W        = 8;
    localparam int          RES_W         = 12;
    localparam int          DIN_W         = 16;
    localparam int          GAIN_W        = 4;

    // register offsets inside the sixteen-port window
    localparam logic [3:0]  OFS_TIMER_ZERO    = 4'h0;
    localparam logic [3:0]  OFS_TIMER_ONE     = 4'h1;
    localparam logic [3:0]  OFS_TIMER_TWO     = 4'h2;
    localparam logic [3:0]  OFS_TIMER_CTRL    = 4'h3;
    localparam logic [3:0]  OFS_RES_LOW       = 4'h4;
    localparam logic [3:0]  OFS_RES_HIGH      = 4'h5;
    localparam logic [3:0]  OFS_DAC1_LOW      = 4'h6;
    localparam logic [3:0]  OFS_DAC1_HIGH     = 4'h7;
    localparam logic [3:0]  OFS_INT_CLEAR     = 4'h8;
    localparam logic [3:0]  OFS_GAIN          = 4'h9;
    localparam logic [3:0]  OFS_CHANNEL       = 4'hA;
    localparam logic [3:0]  OFS_MODE          = 4'hB;
    localparam logic [3:0]  OFS_TRIGGER       = 4'hC;
    localparam logic [3:0]  OFS_DOUT_LOW      = 4'hD;
    localparam logic [3:0]  OFS_DOUT_HIGH     = 4'hE;
    localparam logic [3:0]  OFS_UNUSED        = 4'hF;

    // field positions
    localparam int          BUSY_BIT      = 4;
    localparam int          MODE_W        = 3;
    localparam int          CHAN_W        = 4;

    // reset values, interrupt mode code and reserved read value
    localparam logic [7:0]  RST_BYTE      = 8'h00;
    localparam logic [11:0] RST_DAC       = 12'h000;
    localparam logic [3:0]  RST_GAIN      = 4'h0;
    localparam logic [2:0]  RST_MODE      = 3'h0;
    localparam logic [2:0]  MODE_INTERRUPT = 3'h6;
    localparam logic [7:0]  RD_RESERVED   = 8'h00;

    // gain code fields: bit 3 picks the half-gain family, bit 2 unipolar
    localparam int          GAIN_UNI_BIT  = 2;
    localparam int          GAIN_HALF_BIT = 3;

    // gain settling times the host must wait (microseconds)
    localparam int          SETTLE_MIN_US = 23;
    localparam int          SETTLE_MAX_US = 1300;

    typedef enum logic {LOW_GAIN_VARIANT, HIGH_GAIN_VARIANT} variant_e;

    typedef struct packed {
        logic              bipolar_range;
        logic              unipolar_range;
        logic [1:0]        gain_step;
        logic              half_family;
        logic              code_valid;
    } gain_sel_s;

    typedef struct packed {
        logic              rd;
        logic              wr;
        logic [3:0]        ofs;
        logic [7:0]        data;
    } host_cycle_s;

endpackage

// *** verification/mfio_bank_sva.sv ***
// timing checker for the host-side register bank
// assumes it is bound to mfio_register_bank and sees only its ports
`timescale 1ns/10ps
module mfio_bank_sva
    import mfio_pkg::*;
(
    input wire logic              clk,
    input wire logic              reset_n,
    input wire logic              port_select_n,
    input wire logic [ADDR_W-1:0] port_offset,
    input wire logic              io_read_n,
    input wire logic              io_write_n,
    input wire logic [DATA_W-1:0] host_data_in,
    input wire logic [DATA_W-1:0] host_data_out,
    input wire logic              host_data_oe,
    input wire logic [DATA_W-1:0] timer_data_out,
    input wire logic              timer_data_oe,
    input wire logic [1:0]        timer_addr,
    input wire logic              timer_rd_n,
    input wire logic              timer_wr_n,
    input wire logic              conv_done,
    input wire logic              conv_trigger,
    input wire logic              conv_busy,
    input wire logic              irq_request,
    input wire logic [RES_W-1:0]  dac_first_out,
    input wire logic [GAIN_W-1:0] gain_code_bits,
    input wire logic [MODE_W-1:0] conversion_mode
);
    logic [7:0] wr_data_reg;

    // write data is gone once the strobe rises, so keep it
    always_ff @(posedge clk) begin
        if (!io_write_n) begin
            wr_data_reg <= host_data_in;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence wr_at(logic [3:0] o);
        (!port_select_n && !io_write_n && port_offset == o)[*3]
            ##1 io_write_n;
    endsequence

    a_reserved_read_zero: assert property (
        host_data_oe && port_offset == OFS_UNUSED
            |-> host_data_out == RD_RESERVED)
        else $error("reserved read not zero");
    a_high_byte_pad: assert property (
        host_data_oe && port_offset == OFS_RES_HIGH
            |-> host_data_out[7:5] == 3'b000)
        else $error("high byte pad not zero");
    a_timer_write_pass: assert property (
        (!port_select_n && !io_write_n && port_offset < 4'h4)[*5]
            |-> !timer_wr_n && timer_addr == port_offset[1:0])
        else $error("timer write not passed");
    a_timer_data_drive: assert property (
        (!port_select_n && !io_write_n && port_offset < 4'h4)[*5]
            |-> timer_data_oe && timer_data_out == host_data_in)
        else $error("timer write data wrong");
    a_timer_read_pass: assert property (
        (!port_select_n && !io_read_n && port_offset < OFS_TIMER_CTRL)[*5]
            |-> !timer_rd_n && timer_addr == port_offset[1:0])
        else $error("timer read not passed");
    a_ctrl_read_blocked: assert property (
        (!port_select_n && !io_read_n && port_offset == OFS_TIMER_CTRL)[*5]
            |-> timer_rd_n)
        else $error("control word read passed");
    a_trigger_sets_busy: assert property (
        conv_trigger |-> ##[0:1] conv_busy)
        else $error("trigger without busy");
    a_trigger_one_pulse: assert property (
        conv_trigger |=> !conv_trigger)
        else $error("trigger longer than one cycle");
    a_done_clears_busy: assert property (
        $rose(conv_done) |-> ##[1:5] !conv_busy)
        else $error("busy stuck after done");
    a_done_raises_irq: assert property (
        $rose(conv_done) && conversion_mode == MODE_INTERRUPT
            |-> ##[2:6] irq_request)
        else $error("no irq after done");
    a_clear_drops_irq: assert property (
        wr_at(OFS_INT_CLEAR) |-> ##[1:6] !irq_request)
        else $error("irq not cleared");
    a_low_byte_staged: assert property (
        wr_at(OFS_RES_LOW) |-> $stable(dac_first_out)[*6])
        else $error("dac moved on low byte");
    a_nibble_loads_dac: assert property (
        wr_at(OFS_RES_HIGH)
            |-> ##[2:6] dac_first_out[11:8] == wr_data_reg[3:0])
        else $error("dac nibble wrong");
    a_gain_code_store: assert property (
        wr_at(OFS_GAIN) |-> ##[2:6] gain_code_bits == wr_data_reg[3:0])
        else $error("gain code wrong");
endmodule

bind mfio_register_bank mfio_bank_sva chk_u (.clk(clk), .reset_n(reset_n),
    .port_select_n(port_select_n), .port_offset(port_offset),
    .io_read_n(io_read_n),
    .io_write_n(io_write_n), .host_data_in(host_data_in),
    .host_data_out(host_data_out), .host_data_oe(host_data_oe),
    .timer_data_out(timer_data_out), .timer_data_oe(timer_data_oe),
    .timer_rd_n(timer_rd_n),
    .timer_addr(timer_addr), .timer_wr_n(timer_wr_n),
    .conv_done(conv_done), .conv_trigger(conv_trigger),
    .conv_busy(conv_busy), .irq_request(irq_request),
    .dac_first_out(dac_first_out), .gain_code_bits(gain_code_bits),
    .conversion_mode(conversion_mode));

// *** verification/mfio_host_model.sv ***
// host processor model issuing port reads and writes
// assumes the bank's 3-cycle strobe sync; holds strobes 5 cycles, gaps 5
`timescale 1ns/10ps
module mfio_host_model
    import mfio_pkg::*;
(
    input  wire logic              clk,
    output logic                   port_select_n,
    output logic      [ADDR_W-1:0] port_offset,
    output logic                   io_read_n,
    output logic                   io_write_n,
    output logic      [DATA_W-1:0] host_data_in,
    input  wire logic [DATA_W-1:0] host_data_out
);
    initial begin
        port_select_n = 1'b1;
        port_offset   = 4'h0;
        io_read_n     = 1'b1;
        io_write_n    = 1'b1;
        host_data_in  = 8'h00;
    end

    task automatic access(input logic is_rd, input logic [3:0] o,
                          input logic [7:0] d, output logic [7:0] q);
        @(posedge clk);
        port_select_n <= 1'b0;
        port_offset   <= o;
        host_data_in  <= d;
        io_read_n     <= !is_rd;
        io_write_n    <= is_rd;
        repeat (5) @(posedge clk);
        q = host_data_out;
        port_select_n <= 1'b1;
        io_read_n     <= 1'b1;
        io_write_n    <= 1'b1;
        // released bus shows the inverse so stale data cannot pass
        host_data_in  <= ~d;
        repeat (5) @(posedge clk);
    endtask
endmodule

// *** verification/multifunction_io_register_bank_bench.sv ***
// self-checking bench for the register bank, low-gain variant
// assumes the host model drives the port bus; converter pins driven here
`timescale 1ns/10ps
module multifunction_io_register_bank_bench
    import mfio_pkg::*;
;
    logic clk, reset_n, conv_done, conv_busy, irq_request, timer_wr_n;
    logic pacer_trigger;
    gain_sel_s gain_select_hi;
    logic [3:0] port_offset, gain_code_bits, channel_select;
    logic port_select_n, io_read_n, io_write_n;
    logic [7:0] host_data_in, host_data_out, timer_data_in, q;
    logic [11:0] conv_result, dac_first_out, dac_second_out;
    logic [15:0] digital_input_word, digital_output_word;
    logic [2:0] conversion_mode;
    gain_sel_s gain_select;
    int fail_count, cmp_count, cycles;

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    mfio_host_model host_u (.clk(clk), .port_select_n(port_select_n),
        .port_offset(port_offset), .io_read_n(io_read_n),
        .io_write_n(io_write_n), .host_data_in(host_data_in),
        .host_data_out(host_data_out));

    mfio_register_bank #(.VARIANT(LOW_GAIN_VARIANT)) dut_u (.clk(clk),
        .reset_n(reset_n), .clk_en(1'b1), .port_select_n(port_select_n),
        .port_offset(port_offset), .io_read_n(io_read_n),
        .io_write_n(io_write_n), .host_data_in(host_data_in),
        .host_data_out(host_data_out), .host_data_oe(),
        .timer_data_in(timer_data_in), .timer_data_out(),
        .timer_data_oe(), .timer_addr(), .timer_rd_n(),
        .timer_wr_n(timer_wr_n), .conv_result(conv_result),
        .conv_done(conv_done), .pacer_trigger(pacer_trigger),
        .conv_trigger(),
        .conv_busy(conv_busy), .irq_request(irq_request),
        .digital_input_word(digital_input_word),
        .digital_output_word(digital_output_word),
        .dac_first_out(dac_first_out), .dac_second_out(dac_second_out),
        .gain_code_bits(gain_code_bits), .gain_select(gain_select),
        .channel_select(channel_select), .conversion_mode(conversion_mode));

    // high-gain variant shares the bus; only its gain decode is compared
    mfio_register_bank #(.VARIANT(HIGH_GAIN_VARIANT)) dut_hi_u (.clk(clk),
        .reset_n(reset_n), .clk_en(1'b1), .port_select_n(port_select_n),
        .port_offset(port_offset), .io_read_n(io_read_n),
        .io_write_n(io_write_n), .host_data_in(host_data_in),
        .host_data_out(), .host_data_oe(),
        .timer_data_in(timer_data_in), .timer_data_out(),
        .timer_data_oe(), .timer_addr(), .timer_rd_n(), .timer_wr_n(),
        .conv_result(conv_result), .conv_done(conv_done),
        .pacer_trigger(pacer_trigger), .conv_trigger(), .conv_busy(),
        .irq_request(), .digital_input_word(digital_input_word),
        .digital_output_word(), .dac_first_out(), .dac_second_out(),
        .gain_code_bits(), .gain_select(gain_select_hi),
        .channel_select(), .conversion_mode());

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [3:0] o, input logic [7:0] d);
        logic [7:0] unused;
        host_u.access(1'b0, o, d, unused);
    endtask

    task automatic rd(input logic [3:0] o);
        host_u.access(1'b1, o, 8'h00, q);
    endtask

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic t_dac;
        for (int ch = 0; ch < 2; ch++) begin
            // low byte first, then nibble; upper data bits ignored
            wr(ch ? OFS_DAC1_LOW : OFS_RES_LOW, 8'h5A + 8'(ch));
            check(ch ? dac_second_out : dac_first_out, 16'h0000);
            wr(ch ? OFS_DAC1_HIGH : OFS_RES_HIGH, 8'hF3);
            check(ch ? dac_second_out : dac_first_out, 16'h035A + ch);
            wr(ch ? OFS_DAC1_HIGH : OFS_RES_HIGH, 8'h07);
            check(ch ? dac_second_out : dac_first_out, 16'h075A + ch);
        end
    endtask

    task automatic t_read;
        rd(OFS_DAC1_LOW);
        check(q, 16'h00C3);
        rd(OFS_DAC1_HIGH);
        check(q, 16'h00A5);
        rd(OFS_RES_LOW);
        check(q, 16'h00BC);
        rd(OFS_RES_HIGH);
        check(q, 16'h000A);
        rd(OFS_TIMER_ONE);
        check(q, 16'h0069);
        for (int o = 3; o < 16; o++) begin
            if (o < 4 || o > 7) begin
                rd(o[3:0]);
                check(q, RD_RESERVED);
            end
        end
        wr(OFS_UNUSED, 8'hFF);
        wr(OFS_TIMER_CTRL, 8'h36);
        wr(OFS_CHANNEL, 8'hF9);
        check(channel_select, 16'h0009);
        wr(OFS_DOUT_LOW, 8'h3C);
        wr(OFS_DOUT_HIGH, 8'hC3);
        check(digital_output_word, 16'hC33C);
    endtask

    task automatic t_gain;
        for (int c = 0; c < 16; c++) begin
            wr(OFS_GAIN, {4'hA, c[3:0]});
            check(gain_code_bits, c);
            check(gain_select.code_valid, c <= 8);
            check(gain_select.gain_step, c[1:0]);
            check(gain_select.half_family, c[3]);
            check(gain_select_hi.code_valid, c < 12);
            check(gain_select_hi.unipolar_range, c[3:2] == 2'b01);
            check(gain_select_hi.bipolar_range, c[3:2] != 2'b01);
            check(gain_select_hi.gain_step, c[1:0]);
            if (c <= 8) begin
                check(gain_select.unipolar_range, c[3:2] == 2'b01);
                check(gain_select.bipolar_range, c[3:2] != 2'b01);
            end
        end
    endtask

    task automatic t_conv;
        wr(OFS_MODE, 8'hF6);
        check(conversion_mode, MODE_INTERRUPT);
        wr(OFS_GAIN, 8'h00);
        // settling wait before sampling with a new gain code
        repeat (SETTLE_MIN_US * 50) @(posedge clk);
        for (int n = 0; n < 2; n++) begin
            wr(OFS_TRIGGER, 8'h00);
            rd(OFS_RES_HIGH);
            check(q[BUSY_BIT], 1'b1);
            conv_done <= 1'b1;
            repeat (4) @(posedge clk);
            conv_done <= 1'b0;
            repeat (8) @(posedge clk);
            check(irq_request, 1'b1);
            rd(OFS_RES_HIGH);
            check(q, 16'h000A);
            // service done: clear the status before the next completion
            wr(OFS_INT_CLEAR, 8'hA5);
            check(irq_request, 1'b0);
        end
        // a pacer edge alone starts a conversion
        pacer_trigger <= 1'b1;
        repeat (6) @(posedge clk);
        check(conv_busy, 1'b1);
        pacer_trigger <= 1'b0;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            wrap_up();
        end
    end

    initial begin
        reset_n = 1'b0;
        conv_done = 1'b0;
        pacer_trigger = 1'b0;
        conv_result = 12'hABC;
        timer_data_in = 8'h69;
        digital_input_word = 16'hA5C3;
        fail_count = 0;
        cmp_count = 0;
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        check(dac_first_out, 16'h0000);
        check(dac_second_out, 16'h0000);
        check(timer_wr_n, 1'b1);
        t_dac();
        t_read();
        t_gain();
        t_conv();
        wrap_up();
    end
endmodule
